// file: tb/fccd_decoder_checker.sv
`timescale 1ns/10ps
module fccd_decoder_checker (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic rx_valid,
   input wire logic [7:0] rx_byte,
   input wire logic fault_clear,
   input wire logic print_done,
   input wire logic print_req,
   input wire logic feed_step,
   input wire logic busy,
   input wire logic fault,
   input wire logic [3:0] err_code
);
   import fccd_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   sequence esc_s;
      rx_valid && rx_byte == FCCD_ESC_BYTE && !busy && !fault;
   endsequence
   sequence bad_s;
      rx_valid && !rx_byte[FCCD_SKIP_BIT] &&
         (rx_byte[3:0] > FCCD_MAX_CHAN || rx_byte[3:0] == 4'h0);
   endsequence
   sequence skip_s;
      rx_valid && rx_byte[FCCD_SKIP_BIT];
   endsequence
   chk_skip_prints: assert property (esc_s ##1 skip_s |=> print_req)
      else $error("skip command did not print");
   chk_undef_fault: assert property (esc_s ##1 bad_s |=> fault && err_code == FCCD_ERR_UNDEF)
      else $error("undefined command not faulted");
   chk_fault_holds: assert property (fault && !fault_clear |=> fault)
      else $error("fault dropped");
   chk_fault_quiet: assert property (fault |-> !print_req && !feed_step)
      else $error("activity while faulted");
   chk_print_first: assert property (print_req && !print_done |=> print_req && !feed_step)
      else $error("feed during print");
   chk_feed_after: assert property ($rose(feed_step) |-> $past(print_done))
      else $error("feed without print done");
   chk_req_cause: assert property ($rose(print_req) |-> $past(rx_valid))
      else $error("print without command");
   chk_boot_load: assert property ($rose(arst_n) |-> ##[0:2] busy)
      else $error("no tape read at power-up");
endmodule
bind fccd_decoder fccd_decoder_checker u_chk (.clk, .arst_n, .rx_valid, .rx_byte,
   .fault_clear, .print_done, .print_req, .feed_step, .busy, .fault, .err_code);

// file: tb/fccd_mech_model.sv
`timescale 1ns/10ps
module fccd_mech_model (
   input wire logic clk,
   input wire logic slow,
   input wire logic print_req,
   input wire logic feed_step,
   output logic print_done,
   output logic line_fed
);
   logic [3:0] wait_r = 4'h0;
   // a pulse after a delay, repeating while a request is held; slow mode mimics a sluggish mechanism
   always @(negedge clk) begin
      print_done <= 1'h0;
      line_fed <= 1'h0;
      wait_r <= (print_req || feed_step) ? wait_r + 4'h1 : 4'h0;
      if (wait_r == (slow ? 4'h9 : 4'h1)) begin
         print_done <= print_req;
         line_fed <= feed_step && !print_req;
         wait_r <= 4'h0;
      end
   end
endmodule

// file: tb/tb_fccd_decoder.sv
`timescale 1ns/10ps
module tb_fccd_decoder;
   import fccd_pkg::*;
   logic clk = 0, arst_n = 0, rx_valid = 0, online = 1, tape_rerun_sw = 0, slow = 0;
   logic tape_row_valid = 0, fault_clear = 0;
   logic [7:0] rx_byte = 8'h00, b, panel_page_len = 8'h20, panel_perf_skip = 8'h03;
   logic [11:0] tape_row_holes = 12'h000;
   wire print_done, line_fed, print_req, feed_step, busy, fault, tape_loaded;
   wire [3:0] err_code;
   wire [7:0] line_pos;
   int mismatches = 0, checks_done = 0, seed = 47592, fed = 0, n, k, p;
   always #5 clk = ~clk;
   always @(posedge clk) if (line_fed) fed <= fed + 1;
   fccd_decoder u_fccd_decoder (.clk, .arst_n, .rx_valid, .rx_byte, .online, .tape_rerun_sw,
      .tape_row_valid, .tape_row_holes, .panel_page_len, .panel_perf_skip, .fault_clear,
      .print_done, .line_fed, .print_req, .feed_step, .busy, .fault, .err_code, .line_pos,
      .tape_loaded);
   fccd_mech_model u_fccd_mech_model (.clk, .slow, .print_req, .feed_step, .print_done,
      .line_fed);
   task automatic chk(input logic ok, input string msg);
      checks_done++;
      if (ok !== 1'h1) begin
         mismatches++;
         $display("wrong value at %0t: %s", $time, msg);
      end
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic tick(input int c);
      repeat (c) @(negedge clk);
   endtask
   task automatic put(input logic [7:0] v);
      rx_byte = v;
      rx_valid = 1'h1;
      tick(1);
   endtask
   task automatic wait_idle;
      int j;
      for (j = 0; j < 900 && busy !== 1'h0; j++)
         tick(1);
      if (busy !== 1'h0) begin
         mismatches++;
         $display("wrong value at %0t: %s", $time, "timeout");
         conclude;
      end
   endtask
   // five-line form: channel 1 on line 0, channel 2 on line 2, channel 12 on line 3
   function automatic logic [11:0] tape_row(input int j);
      case (j % 5)
         0: return 12'h001;
         2: return 12'h002;
         3: return 12'h800;
         default: return 12'h000;
      endcase
   endfunction
   // line reached after a command: n counted lines, or the next row holding the channel
   function automatic int exp_pos(input int q, input logic [7:0] v, input bit panel);
      int c, len, lim;
      logic [11:0] r;
      len = panel ? int'(panel_page_len) : 5;
      lim = (panel && panel_page_len > panel_perf_skip) ? len - int'(panel_perf_skip) : len;
      c = 0;
      if (v[FCCD_SKIP_BIT]) begin
         while (c < v[3:0]) begin
            q = (q + 1) % len;
            if (q < lim)
               c++;
         end
      end else begin
         for (c = 0; c < len; c++) begin
            q = (q + 1) % len;
            r = tape_row(q);
            if (r[v[3:0] - 4'h1])
               break;
         end
      end
      return q;
   endfunction
   // the five-line loop closed by a sixth row, or a blank loop too long to hold
   task automatic feed_tape(input int rows, input bit blank);
      int j;
      for (j = 0; j < rows; j++) begin
         tape_row_holes = (blank && j != 0) ? 12'h000 : tape_row(j);
         tape_row_valid = 1'h1;
         tick(1);
         tape_row_valid = 1'h0;
         tick(1);
      end
   endtask
   function automatic logic [3:0] exp_err(input logic [7:0] v);
      if (v[FCCD_SKIP_BIT])
         return FCCD_ERR_NONE;
      if (v[3:0] > FCCD_MAX_CHAN || v[3:0] == 4'h0)
         return FCCD_ERR_UNDEF;
      return v[3:0] inside {4'h1, 4'h2, 4'hC} ? FCCD_ERR_NONE : FCCD_ERR_NOCHAN;
   endfunction
   initial begin
      tick(2);
      arst_n = 1'h1;
      tick(3);
      feed_tape(6, 1'b0);
      wait_idle;
      chk(tape_loaded === 1'h1 && fault === 1'h0, "power-up load");
      put(8'h41);
      rx_valid = 1'h0;
      tick(3);
      chk(print_req === 1'h0 && busy === 1'h0, "stray byte");
      for (k = 0; k < 32; k++) begin
         b = 8'($random(seed));
         b[FCCD_SKIP_BIT] = !k[4];
         b[3:0] = k[3:0];
         slow = b[7];
         n = fed;
         p = line_pos;
         put(FCCD_ESC_BYTE);
         put(b);
         rx_valid = 1'h0;
         tick(2);
         if (exp_err(b) !== FCCD_ERR_NONE) begin
            chk(fault === 1'h1 && err_code === exp_err(b), "fault code");
            put(FCCD_ESC_BYTE);
            put(8'h13);
            rx_valid = 1'h0;
            tick(3);
            chk(print_req === 1'h0 && fault === 1'h1, "fault blocks");
            fault_clear = 1'h1;
            tick(1);
            fault_clear = 1'h0;
            tick(1);
            chk(fault === 1'h0, "fault clear");
         end else begin
            wait_idle;
            chk(fault === 1'h0 && (!b[FCCD_SKIP_BIT] || fed - n == b[3:0]), "feed");
            chk(line_pos === 8'(exp_pos(p, b, 1'b0)), "line position");
         end
      end
      tape_rerun_sw = 1'h1;
      tick(6);
      tape_rerun_sw = 1'h0;
      tick(2);
      chk(busy === 1'h0, "rerun online");
      online = 1'h0;
      tick(4);
      tape_rerun_sw = 1'h1;
      tick(6);
      chk(busy === 1'h1, "rerun offline");
      tape_rerun_sw = 1'h0;
      feed_tape(6, 1'b0);
      wait_idle;
      chk(tape_loaded === 1'h1, "reload");
      // an overlong loop leaves no tape format, so the panel page takes over
      tape_rerun_sw = 1'h1;
      tick(6);
      tape_rerun_sw = 1'h0;
      feed_tape(257, 1'b1);
      wait_idle;
      chk(fault === 1'h1 && err_code === FCCD_ERR_TAPE && tape_loaded === 1'h0, "long tape");
      fault_clear = 1'h1;
      tick(1);
      fault_clear = 1'h0;
      tick(1);
      for (k = 0; k < 8; k++) begin
         b = 8'($random(seed));
         b[FCCD_SKIP_BIT] = 1'h1;
         if (k == 0)
            b[3:0] = 4'hF;
         slow = b[7];
         p = line_pos;
         put(FCCD_ESC_BYTE);
         put(b);
         rx_valid = 1'h0;
         wait_idle;
         chk(fault === 1'h0 && line_pos === 8'(exp_pos(p, b, 1'b1)), "panel page");
      end
      conclude;
   end
endmodule

// file: verilog/fccd_decoder.sv
`timescale 1ns/10ps
module fccd_decoder #(
   parameter int NCHAN = fccd_pkg::FCCD_NCHAN,
   parameter int LINE_W = fccd_pkg::FCCD_LINE_W
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic rx_valid,
   input wire logic [7:0] rx_byte,
   input wire logic online,
   input wire logic tape_rerun_sw,
   input wire logic tape_row_valid,
   input wire logic [NCHAN-1:0] tape_row_holes,
   input wire logic [LINE_W-1:0] panel_page_len,
   input wire logic [LINE_W-1:0] panel_perf_skip,
   input wire logic fault_clear,
   input wire logic print_done,
   input wire logic line_fed,
   output logic print_req,
   output logic feed_step,
   output logic busy,
   output logic fault,
   output logic [3:0] err_code,
   output logic [LINE_W-1:0] line_pos,
   output logic tape_loaded
);
   import fccd_pkg::*;
   initial begin
      if (NCHAN != 6 && NCHAN != 12) $error("channel count must be 6 or 12");
      if (LINE_W < 8) $error("line index too narrow");
   end
   localparam int DEPTH = 1 << LINE_W;

   // ************************
   // pin synchronisers
   // ************************
   logic sw_m_r, sw_s_r, sw_d_r, on_m_r, on_s_r;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sw_m_r <= 1'b0;
         sw_s_r <= 1'b0;
         sw_d_r <= 1'b0;
         on_m_r <= 1'b0;
         on_s_r <= 1'b0;
      end else begin
         sw_m_r <= tape_rerun_sw;
         sw_s_r <= sw_m_r;
         sw_d_r <= sw_s_r;
         on_m_r <= online;
         on_s_r <= on_m_r;
      end
   end
   wire sw_press = sw_s_r && !sw_d_r;

   // ************************
   // tape load and forms control buffer
   // ************************
   logic pwr_up_r;
   logic [NCHAN-1:0] forms_control_buffer [DEPTH];
   logic [LINE_W-1:0] form_len_r;
   logic [NCHAN-1:0] loaded_chan_r;
   wire ld_busy, ld_wr, ld_done, ld_ovf;
   wire [LINE_W-1:0] ld_addr;
   wire [NCHAN-1:0] ld_data;
   wire tape_start = pwr_up_r || (sw_press && !on_s_r);
   fccd_tape_loader #(.NCHAN(NCHAN), .LINE_W(LINE_W)) u_loader (
      .clk(clk),
      .arst_n(arst_n),
      .start(tape_start),
      .row_valid(tape_row_valid),
      .row_holes(tape_row_holes),
      .busy(ld_busy),
      .wr_en(ld_wr),
      .wr_addr(ld_addr),
      .wr_data(ld_data),
      .done(ld_done),
      .overflow(ld_ovf)
   );
   always_ff @(posedge clk) begin
      if (ld_wr) forms_control_buffer[ld_addr] <= ld_data;
   end

   // ************************
   // command decode
   // ************************
   typedef enum logic [2:0] {FCCD_IDLE, FCCD_ARMED, FCCD_PRINT, FCCD_FEED} fccd_st_e;
   fccd_st_e st_r, st_nxt;
   logic [3:0] cmd_r;
   logic skip_mode_r;
   logic [4:0] remain_r;
   logic [LINE_W-1:0] pos_r;
   logic fault_r;
   logic [3:0] err_r;
   logic loaded_r;

   wire [3:0] nib = rx_byte[3:0];
   wire is_skip = rx_byte[FCCD_SKIP_BIT];
   wire chan_ok = (nib != 4'h0) && (nib <= FCCD_MAX_CHAN) && (32'(nib) <= NCHAN);
   wire chan_present = loaded_r && chan_ok && loaded_chan_r[nib - 4'h1];
   wire undef = !is_skip && !chan_ok;
   wire cmd_take = (st_r == FCCD_ARMED) && rx_valid;
   wire cmd_bad = cmd_take && (undef || (!is_skip && !chan_present));
   // page wraps at the loaded tape form length, or at the panel page when no tape is loaded; panel perforation band is jumped over
   wire [LINE_W-1:0] page_len = loaded_r ? form_len_r : panel_page_len;
   wire [LINE_W-1:0] pos_inc = (pos_r + 1'b1 >= page_len) ? '0 : pos_r + 1'b1;
   wire in_perf = !loaded_r && (panel_page_len > panel_perf_skip) &&
                  (pos_inc >= panel_page_len - panel_perf_skip);
   wire [NCHAN-1:0] row_at = forms_control_buffer[pos_inc];
   wire chan_hit = skip_mode_r ? 1'b0 : row_at[cmd_r - 4'h1];
   wire feed_last = skip_mode_r ? (remain_r <= 5'd1 && !in_perf) : chan_hit;

   always_comb begin
      st_nxt = st_r;
      case (st_r)
         FCCD_IDLE: if (rx_valid && rx_byte == FCCD_ESC_BYTE && !fault_r && !ld_busy)
            st_nxt = FCCD_ARMED;
         FCCD_ARMED: if (rx_valid) st_nxt = cmd_bad ? FCCD_IDLE : FCCD_PRINT;
         FCCD_PRINT: if (print_done)
            st_nxt = (skip_mode_r && cmd_r == 4'h0) ? FCCD_IDLE : FCCD_FEED;
         FCCD_FEED: if (line_fed && feed_last) st_nxt = FCCD_IDLE;
         default: st_nxt = FCCD_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_r <= FCCD_IDLE;
         cmd_r <= 4'h0;
         skip_mode_r <= 1'b0;
         remain_r <= 5'd0;
         pwr_up_r <= 1'b1;
      end else begin
         st_r <= st_nxt;
         pwr_up_r <= 1'b0;
         if (cmd_take) begin
            cmd_r <= nib;
            skip_mode_r <= is_skip;
            remain_r <= {1'b0, nib};
         end else if (st_r == FCCD_FEED && line_fed && !in_perf && remain_r != 5'd0) begin
            remain_r <= remain_r - 5'd1;
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pos_r <= '0;
      end else if (st_r == FCCD_FEED && line_fed) begin
         pos_r <= pos_inc;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         loaded_r <= 1'b0;
         loaded_chan_r <= '0;
         form_len_r <= '0;
      end else if (tape_start) begin
         loaded_r <= 1'b0;
         loaded_chan_r <= '0;
      end else begin
         if (ld_wr) loaded_chan_r <= loaded_chan_r | ld_data;
         if (ld_wr) form_len_r <= ld_addr + 1'b1;
         if (ld_done) loaded_r <= 1'b1;
      end
   end

   // fault setting wins over an operator clear in the same cycle
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         fault_r <= 1'b0;
         err_r <= FCCD_ERR_NONE;
      end else if (cmd_bad) begin
         fault_r <= 1'b1;
         err_r <= undef ? FCCD_ERR_UNDEF : FCCD_ERR_NOCHAN;
      end else if (ld_ovf) begin
         fault_r <= 1'b1;
         err_r <= FCCD_ERR_TAPE;
      end else if (fault_clear) begin
         fault_r <= 1'b0;
         err_r <= FCCD_ERR_NONE;
      end
   end

   assign print_req = (st_r == FCCD_PRINT);
   assign feed_step = (st_r == FCCD_FEED);
   assign busy = (st_r != FCCD_IDLE) || ld_busy;
   assign fault = fault_r;
   assign err_code = err_r;
   assign line_pos = pos_r;
   assign tape_loaded = loaded_r;
endmodule

// file: verilog/fccd_pkg.sv
package fccd_pkg;
   localparam logic [7:0] FCCD_ESC_BYTE = 8'h1F;
   // "bit 5" counts from one: hex 10 to 1F are the skip codes, so it is bit 4 here
   localparam int FCCD_SKIP_BIT = 4;
   localparam logic [3:0] FCCD_MAX_CHAN = 4'hC;
   localparam int FCCD_NCHAN = 12;
   localparam int FCCD_MAX_LINES = 176;
   localparam int FCCD_LINE_W = 8;
   // fault codes shown on the status display
   localparam logic [3:0] FCCD_ERR_NONE = 4'h0;
   localparam logic [3:0] FCCD_ERR_UNDEF = 4'h1;
   localparam logic [3:0] FCCD_ERR_NOCHAN = 4'h2;
   localparam logic [3:0] FCCD_ERR_TAPE = 4'h3;
   localparam logic [7:0] FCCD_RST_PAGE_LEN = 8'h42;
endpackage

// file: verilog/fccd_tape_loader.sv
`timescale 1ns/10ps
// ************************
// tape reader capture
// ************************
module fccd_tape_loader #(
   parameter int NCHAN = fccd_pkg::FCCD_NCHAN,
   parameter int LINE_W = fccd_pkg::FCCD_LINE_W
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic start,
   input wire logic row_valid,
   input wire logic [NCHAN-1:0] row_holes,
   output logic busy,
   output logic wr_en,
   output logic [LINE_W-1:0] wr_addr,
   output logic [NCHAN-1:0] wr_data,
   output logic done,
   output logic overflow
);
   import fccd_pkg::*;
   initial begin
      if (NCHAN < 1 || LINE_W < 1) $error("bad loader size");
   end
   typedef enum logic [1:0] {FCCD_T_IDLE, FCCD_T_SEEK, FCCD_T_LOAD} fccd_tst_e;
   fccd_tst_e st_r, st_nxt;
   logic [LINE_W-1:0] addr_r;
   wire top_row = row_valid && row_holes[0];
   wire at_end = (addr_r == {LINE_W{1'b1}});
   always_comb begin
      st_nxt = st_r;
      case (st_r)
         FCCD_T_IDLE: if (start) st_nxt = FCCD_T_SEEK;
         FCCD_T_SEEK: if (top_row) st_nxt = FCCD_T_LOAD;
         FCCD_T_LOAD: if (top_row || (row_valid && at_end)) st_nxt = FCCD_T_IDLE;
         default: st_nxt = FCCD_T_IDLE;
      endcase
   end
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_r <= FCCD_T_IDLE;
         addr_r <= '0;
      end else begin
         st_r <= st_nxt;
         if (st_r == FCCD_T_SEEK) addr_r <= '0;
         else if (st_r == FCCD_T_LOAD && row_valid && !top_row) addr_r <= addr_r + 1'b1;
      end
   end
   // first channel-1 row is line 0; rows follow until the next channel-1 row
   assign wr_en = row_valid && ((st_r == FCCD_T_SEEK && top_row) ||
                  (st_r == FCCD_T_LOAD && !top_row && !at_end));
   assign wr_addr = (st_r == FCCD_T_SEEK) ? '0 : addr_r + 1'b1;
   assign wr_data = row_holes;
   assign busy = (st_r != FCCD_T_IDLE);
   assign done = (st_r == FCCD_T_LOAD) && top_row;
   assign overflow = (st_r == FCCD_T_LOAD) && row_valid && at_end && !top_row;
endmodule
